// ### hw/csfr_defines.vh
`ifndef CSFR_DEFINES_VH
`define CSFR_DEFINES_VH

// register indices; byte address is four times the index
`define CSFR_IDX_LOW_PORT    10'h080
`define CSFR_IDX_STACK_TOP   10'h081
`define CSFR_IDX_DPTR_LOW    10'h082
`define CSFR_IDX_DPTR_HIGH   10'h083
`define CSFR_IDX_PULLUP_SEL  10'h086
`define CSFR_IDX_POWER_CTRL  10'h087
`define CSFR_IDX_TIMER_CTRL  10'h088
`define CSFR_IDX_SERIAL_CTRL 10'h098
`define CSFR_IDX_IRQ_STATUS  10'h100
`define CSFR_IDX_IRQ_MASK    10'h101
`define CSFR_SFR_BASE_HI     3'h1

// power_control fields
`define CSFR_PC_BAUD_DBL     7
`define CSFR_PC_FE_SEL       6
`define CSFR_PC_POR          4
`define CSFR_PC_UF1          3
`define CSFR_PC_UF0          2
`define CSFR_PC_PD           1
`define CSFR_PC_IDL          0

// timer_control fields
`define CSFR_TC_TF1          7
`define CSFR_TC_TR1          6
`define CSFR_TC_TF0          5
`define CSFR_TC_TR0          4
`define CSFR_TC_IE1          3
`define CSFR_TC_IT1          2
`define CSFR_TC_IE0          1
`define CSFR_TC_IT0          0

// serial_control field, pull-up field
`define CSFR_SC_MODE_FE      7
`define CSFR_PU_EN           0

// interrupt status bits
`define CSFR_IRQ_T0_OVF      0
`define CSFR_IRQ_T1_OVF      1
`define CSFR_IRQ_EXT0        2
`define CSFR_IRQ_EXT1        3
`define CSFR_IRQ_FRAME_ERR   4
`define CSFR_IRQ_W           5

// reset values
`define CSFR_RST_LOW_PORT    8'hFF
`define CSFR_RST_STACK_TOP   8'h07
`define CSFR_RST_DPTR        8'h00
`define CSFR_RST_PULLUP      1'b1
`define CSFR_RST_POWER_CTRL  8'h30
`define CSFR_RST_TIMER_CTRL  8'h00
`define CSFR_UNIMPL_BYTE     8'hFF

// AXI responses
`define CSFR_RESP_OKAY       2'h0
`define CSFR_RESP_SLVERR     2'h2

`endif

// ### hw/csfr_low_page.v
// How it works
// - pull-up bit zero gives open-drain, one pulls up
// - external access drives multiplexed address/data byte
// - stack pointer byte, reset value seven
// - two data pointer bytes form 16 bits
// - baud doubler bit doubles serial modes 1-3
// - select bit swaps serial bit7 mode/error
// - power-on flag set by reset, software clears
// - two user flags, plain storage
// - power-down request stops all clocks
// - idle request stops only cpu clock
// - overflow flags set, vector clears, software writes
// - run bits are software-written timer enables
// - external flags set on selected edge/level
// - vectoring clears edge flags, not level flags
// - level mode flag follows inverted pin
// - trigger-type bits are software written
// - unimplemented bits and registers in the page read one, addresses outside it read zero except irq status/mask, whose upper three bits read zero
`include "csfr_defines.vh"

module csfr_low_page #(
    parameter ADDR_W = 12
) (
    // clock and reset
    input  wire              aclk,
    input  wire              aresetn,
    // axi4-lite slave
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // low port pins
    input  wire [7:0]        low_port_in,
    output reg  [7:0]        low_port_out_q,
    output reg  [7:0]        low_port_oe_n_q,
    output reg               low_port_pullup_enable_q,
    // external memory bus
    input  wire              ext_access,
    input  wire              ext_addr_phase,
    input  wire              ext_write_phase,
    input  wire [7:0]        ext_addr_low,
    input  wire [7:0]        ext_wdata,
    output reg  [7:0]        ext_rdata_q,
    // core views
    output reg  [7:0]        stack_top_q,
    output reg  [15:0]       data_pointer_q,
    // power and clock control
    input  wire              power_on_reset,
    input  wire              wake_event,
    output reg               cpu_clk_stop_q,
    output reg               periph_clk_stop_q,
    // serial port link
    input  wire              frame_err_event,
    output reg               baud_doubler_q,
    output reg               serial_mode_hi_q,
    // timers
    input  wire              first_timer_ovf_evt,
    input  wire              second_timer_ovf_evt,
    input  wire              first_timer_vector,
    input  wire              second_timer_vector,
    output reg               first_timer_run_q,
    output reg               second_timer_run_q,
    // external interrupts
    input  wire              ext_irq0_pin,
    input  wire              ext_irq1_pin,
    input  wire              ext_irq0_vector,
    input  wire              ext_irq1_vector,
    output reg  [7:0]        timer_control_q,
    // interrupt
    output reg               irq_q
);

////////////////////////////////////////////////////////////////////////////
// axi4-lite slave

reg  [ADDR_W-1:0] awaddr_q;
reg  [7:0]        wbyte_q;
reg               wlane_q;
reg               aw_held_q;
reg               w_held_q;
wire              aw_fire = s_axi_awvalid & s_axi_awready;
wire              w_fire  = s_axi_wvalid & s_axi_wready;
wire              wr_go   = aw_held_q & w_held_q & ~s_axi_bvalid;
wire [9:0]        wr_idx  = awaddr_q[11:2];
wire              wr_en   = wr_go & wlane_q;
wire              wr_map  = (wr_idx[9:7] == `CSFR_SFR_BASE_HI) |
                            (wr_idx == `CSFR_IDX_IRQ_STATUS) |
                            (wr_idx == `CSFR_IDX_IRQ_MASK);

always @(posedge aclk) begin
    if (!aresetn) begin
        awaddr_q      <= {ADDR_W{1'b0}};
        wbyte_q       <= 8'h00;
        wlane_q       <= 1'b0;
        aw_held_q     <= 1'b0;
        w_held_q      <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `CSFR_RESP_OKAY;
    end else begin
        s_axi_awready <= ~aw_held_q & ~aw_fire & ~s_axi_bvalid;
        s_axi_wready  <= ~w_held_q & ~w_fire & ~s_axi_bvalid;
        if (aw_fire) begin
            awaddr_q  <= s_axi_awaddr;
            aw_held_q <= 1'b1;
        end
        if (w_fire) begin
            wbyte_q  <= s_axi_wdata[7:0];
            wlane_q  <= s_axi_wstrb[0];
            w_held_q <= 1'b1;
        end
        if (wr_go) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_map ? `CSFR_RESP_OKAY : `CSFR_RESP_SLVERR;
        end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

wire       ar_fire = s_axi_arvalid & s_axi_arready;
wire [9:0] rd_idx  = s_axi_araddr[11:2];
reg  [7:0] rd_byte;
reg        rd_map;

////////////////////////////////////////////////////////////////////////////
// pin synchronisers: three stages, change taken when stages 2 and 3 agree

reg [9:0] pin_s1_q;
reg [9:0] pin_s2_q;
reg [9:0] pin_s3_q;
reg [9:0] pin_f_q;
reg [1:0] irq_prev_q;
wire [9:0] pin_raw = {ext_irq1_pin, ext_irq0_pin, low_port_in};
wire [9:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);

always @(posedge aclk) begin
    if (!aresetn) begin
        pin_s1_q   <= 10'h3FF;
        pin_s2_q   <= 10'h3FF;
        pin_s3_q   <= 10'h3FF;
        pin_f_q    <= 10'h3FF;
        irq_prev_q <= 2'h3;
    end else begin
        pin_s1_q   <= pin_raw;
        pin_s2_q   <= pin_s1_q;
        pin_s3_q   <= pin_s2_q;
        pin_f_q    <= (pin_agree & pin_s3_q) | (~pin_agree & pin_f_q);
        irq_prev_q <= pin_f_q[9:8];
    end
end

wire [1:0] irq_pin   = pin_f_q[9:8];
wire [1:0] irq_fall  = irq_prev_q & ~irq_pin;

////////////////////////////////////////////////////////////////////////////
// port, pointers, power control

reg  [7:0] port_latch_q;
reg  [7:0] power_ctrl_q;
reg        fe_status_q;
reg        sm_hi_q;

function wr_hit;
    input [9:0] idx;
    begin
        wr_hit = wr_en & (wr_idx == idx);
    end
endfunction

always @(posedge aclk) begin
    if (!aresetn) begin
        port_latch_q             <= `CSFR_RST_LOW_PORT;
        stack_top_q              <= `CSFR_RST_STACK_TOP;
        data_pointer_q           <= {`CSFR_RST_DPTR, `CSFR_RST_DPTR};
        low_port_pullup_enable_q <= `CSFR_RST_PULLUP;
        sm_hi_q                  <= 1'b0;
    end else begin
        if (wr_hit(`CSFR_IDX_LOW_PORT))
            port_latch_q <= wbyte_q;
        if (wr_hit(`CSFR_IDX_STACK_TOP))
            stack_top_q <= wbyte_q;
        if (wr_hit(`CSFR_IDX_DPTR_LOW))
            data_pointer_q[7:0] <= wbyte_q;
        if (wr_hit(`CSFR_IDX_DPTR_HIGH))
            data_pointer_q[15:8] <= wbyte_q;
        if (wr_hit(`CSFR_IDX_PULLUP_SEL))
            low_port_pullup_enable_q <= wbyte_q[`CSFR_PU_EN];
        if (wr_hit(`CSFR_IDX_SERIAL_CTRL) &
            ~power_ctrl_q[`CSFR_PC_FE_SEL])
            sm_hi_q <= wbyte_q[`CSFR_SC_MODE_FE];
    end
end

// drive: address/data in external cycles, else pull low where latch is 0
always @(posedge aclk) begin
    if (!aresetn) begin
        low_port_out_q  <= 8'h00;
        low_port_oe_n_q <= 8'hFF;
        ext_rdata_q     <= 8'h00;
    end else begin
        ext_rdata_q <= pin_f_q[7:0];
        if (ext_access) begin
            low_port_out_q  <= ext_addr_phase ? ext_addr_low : ext_wdata;
            low_port_oe_n_q <= {8{~(ext_addr_phase | ext_write_phase)}};
        end else begin
            // ones float; the pull-up, when enabled, makes them high
            low_port_out_q  <= 8'h00;
            low_port_oe_n_q <= port_latch_q;
        end
    end
end

wire pc_wr = wr_hit(`CSFR_IDX_POWER_CTRL);

always @(posedge aclk) begin
    if (!aresetn) begin
        power_ctrl_q <= `CSFR_RST_POWER_CTRL;
    end else begin
        if (pc_wr) begin
            power_ctrl_q[7:6] <= wbyte_q[7:6];
            power_ctrl_q[3:2] <= wbyte_q[3:2];
            power_ctrl_q[`CSFR_PC_POR] <= wbyte_q[`CSFR_PC_POR];
        end
        if (power_on_reset)
            power_ctrl_q[`CSFR_PC_POR] <= 1'b1;
        // wake has priority; a frozen core cannot clear these itself
        if (wake_event) begin
            power_ctrl_q[`CSFR_PC_PD]  <= 1'b0;
            power_ctrl_q[`CSFR_PC_IDL] <= 1'b0;
        end else if (pc_wr) begin
            power_ctrl_q[`CSFR_PC_PD]  <= wbyte_q[`CSFR_PC_PD];
            power_ctrl_q[`CSFR_PC_IDL] <= wbyte_q[`CSFR_PC_IDL];
        end
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        cpu_clk_stop_q    <= 1'b0;
        periph_clk_stop_q <= 1'b0;
        baud_doubler_q    <= 1'b0;
        serial_mode_hi_q  <= 1'b0;
    end else begin
        cpu_clk_stop_q    <= power_ctrl_q[`CSFR_PC_PD] |
                             power_ctrl_q[`CSFR_PC_IDL];
        periph_clk_stop_q <= power_ctrl_q[`CSFR_PC_PD];
        baud_doubler_q    <= power_ctrl_q[`CSFR_PC_BAUD_DBL];
        serial_mode_hi_q  <= sm_hi_q;
    end
end

// framing error status; a new error wins over a software clear
always @(posedge aclk) begin
    if (!aresetn)
        fe_status_q <= 1'b0;
    else if (frame_err_event)
        fe_status_q <= 1'b1;
    else if (wr_hit(`CSFR_IDX_SERIAL_CTRL) & power_ctrl_q[`CSFR_PC_FE_SEL])
        fe_status_q <= wbyte_q[`CSFR_SC_MODE_FE];
end

////////////////////////////////////////////////////////////////////////////
// timer control

reg  [7:0] tc_q;
reg  [7:0] tc_d;
wire       tc_wr = wr_hit(`CSFR_IDX_TIMER_CTRL);
wire [1:0] it_bit = {tc_q[`CSFR_TC_IT1], tc_q[`CSFR_TC_IT0]};
wire [1:0] ext_vec = {ext_irq1_vector, ext_irq0_vector};
wire [1:0] ext_sw = {wbyte_q[`CSFR_TC_IE1], wbyte_q[`CSFR_TC_IE0]};
reg  [1:0] ext_cur;
reg  [1:0] ext_nxt;
integer    k;

always @* begin
    tc_d    = tc_q;
    ext_cur = {tc_q[`CSFR_TC_IE1], tc_q[`CSFR_TC_IE0]};
    ext_nxt = ext_cur;
    if (tc_wr) begin
        tc_d[`CSFR_TC_TR1] = wbyte_q[`CSFR_TC_TR1];
        tc_d[`CSFR_TC_TR0] = wbyte_q[`CSFR_TC_TR0];
        tc_d[`CSFR_TC_IT1] = wbyte_q[`CSFR_TC_IT1];
        tc_d[`CSFR_TC_IT0] = wbyte_q[`CSFR_TC_IT0];
        tc_d[`CSFR_TC_TF1] = wbyte_q[`CSFR_TC_TF1];
        tc_d[`CSFR_TC_TF0] = wbyte_q[`CSFR_TC_TF0];
    end
    // overflow wins over both vector clear and software clear
    if (second_timer_ovf_evt)
        tc_d[`CSFR_TC_TF1] = 1'b1;
    else if (second_timer_vector)
        tc_d[`CSFR_TC_TF1] = 1'b0;
    if (first_timer_ovf_evt)
        tc_d[`CSFR_TC_TF0] = 1'b1;
    else if (first_timer_vector)
        tc_d[`CSFR_TC_TF0] = 1'b0;
    for (k = 0; k < 2; k = k + 1) begin
        if (!it_bit[k])
            ext_nxt[k] = ~irq_pin[k];
        else if (irq_fall[k])
            ext_nxt[k] = 1'b1;
        else if (ext_vec[k])
            ext_nxt[k] = 1'b0;
        else if (tc_wr)
            ext_nxt[k] = ext_sw[k];
    end
    tc_d[`CSFR_TC_IE1] = ext_nxt[1];
    tc_d[`CSFR_TC_IE0] = ext_nxt[0];
end

always @(posedge aclk) begin
    if (!aresetn) begin
        tc_q               <= `CSFR_RST_TIMER_CTRL;
        timer_control_q    <= `CSFR_RST_TIMER_CTRL;
        first_timer_run_q  <= 1'b0;
        second_timer_run_q <= 1'b0;
    end else begin
        tc_q               <= tc_d;
        timer_control_q    <= tc_d;
        first_timer_run_q  <= tc_d[`CSFR_TC_TR0];
        second_timer_run_q <= tc_d[`CSFR_TC_TR1];
    end
end

////////////////////////////////////////////////////////////////////////////
// interrupt status and mask

reg  [`CSFR_IRQ_W-1:0] irq_status_q;
reg  [`CSFR_IRQ_W-1:0] irq_mask_q;
wire [`CSFR_IRQ_W-1:0] irq_evt = {
    frame_err_event,
    tc_d[`CSFR_TC_IE1] & ~tc_q[`CSFR_TC_IE1],
    tc_d[`CSFR_TC_IE0] & ~tc_q[`CSFR_TC_IE0],
    second_timer_ovf_evt,
    first_timer_ovf_evt};
wire [`CSFR_IRQ_W-1:0] irq_w1c = wr_hit(`CSFR_IDX_IRQ_STATUS) ?
                                 wbyte_q[`CSFR_IRQ_W-1:0] :
                                 {`CSFR_IRQ_W{1'b0}};

always @(posedge aclk) begin
    if (!aresetn) begin
        irq_status_q <= {`CSFR_IRQ_W{1'b0}};
        irq_mask_q   <= {`CSFR_IRQ_W{1'b0}};
        irq_q        <= 1'b0;
    end else begin
        // set wins over a same-cycle write-one clear
        irq_status_q <= (irq_status_q & ~irq_w1c) | irq_evt;
        if (wr_hit(`CSFR_IDX_IRQ_MASK))
            irq_mask_q <= wbyte_q[`CSFR_IRQ_W-1:0];
        irq_q <= |(irq_status_q & irq_mask_q);
    end
end

////////////////////////////////////////////////////////////////////////////
// read path

always @* begin
    rd_map  = 1'b1;
    rd_byte = `CSFR_UNIMPL_BYTE;
    case (rd_idx)
        `CSFR_IDX_LOW_PORT:   rd_byte = pin_f_q[7:0];
        `CSFR_IDX_STACK_TOP:  rd_byte = stack_top_q;
        `CSFR_IDX_DPTR_LOW:   rd_byte = data_pointer_q[7:0];
        `CSFR_IDX_DPTR_HIGH:  rd_byte = data_pointer_q[15:8];
        `CSFR_IDX_PULLUP_SEL: rd_byte = {7'h7F, low_port_pullup_enable_q};
        `CSFR_IDX_POWER_CTRL: rd_byte = power_ctrl_q | 8'h20;
        `CSFR_IDX_TIMER_CTRL: rd_byte = tc_q;
        `CSFR_IDX_SERIAL_CTRL: rd_byte = {power_ctrl_q[`CSFR_PC_FE_SEL] ?
                                          fe_status_q : sm_hi_q,
                                          7'h7F};
        `CSFR_IDX_IRQ_STATUS: rd_byte = {3'h0, irq_status_q};
        `CSFR_IDX_IRQ_MASK:   rd_byte = {3'h0, irq_mask_q};
        default: begin
            rd_map = (rd_idx[9:7] == `CSFR_SFR_BASE_HI);
            if (!rd_map)
                rd_byte = 8'h00;
        end
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rdata   <= 32'h00000000;
        s_axi_rresp   <= `CSFR_RESP_OKAY;
    end else begin
        s_axi_arready <= ~s_axi_rvalid & ~ar_fire;
        if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
            s_axi_rresp  <= rd_map ? `CSFR_RESP_OKAY : `CSFR_RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule

// ### testbench/csfr_low_page_props.sv
module csfr_low_page_props (
    // clock and reset
    input wire        aclk,
    input wire        aresetn,
    // bus handshakes
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    // port and external bus
    input wire [7:0]  low_port_out_q,
    input wire [7:0]  low_port_oe_n_q,
    input wire        ext_access,
    input wire        ext_addr_phase,
    input wire        ext_write_phase,
    input wire [7:0]  ext_addr_low,
    input wire [7:0]  ext_wdata,
    // power and timers
    input wire        wake_event,
    input wire        cpu_clk_stop_q,
    input wire        periph_clk_stop_q,
    input wire        first_timer_ovf_evt,
    input wire        second_timer_ovf_evt,
    input wire [7:0]  timer_control_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////
    chk_ext_addr: assert property (
        ext_access && ext_addr_phase |=> low_port_oe_n_q == 8'h00
        && low_port_out_q == $past(ext_addr_low))
        else $error("address byte not driven on port");
    chk_ext_data: assert property (
        ext_access && !ext_addr_phase && ext_write_phase
        |=> low_port_oe_n_q == 8'h00 && low_port_out_q == $past(ext_wdata))
        else $error("data byte not driven on port");
    chk_ext_release: assert property (
        ext_access && !ext_addr_phase && !ext_write_phase
        |=> low_port_oe_n_q == 8'hFF)
        else $error("port not released between phases");
    chk_open_drain: assert property (
        !ext_access |=> low_port_out_q == 8'h00)
        else $error("port drives high outside bus cycles");
    chk_clock_stops: assert property (
        wake_event |-> ##2 !cpu_clk_stop_q && !periph_clk_stop_q)
        else $error("clocks not restarted after wake");
    chk_ovf_first: assert property (
        first_timer_ovf_evt |=> timer_control_q[5])
        else $error("first overflow flag not set");
    chk_ovf_second: assert property (
        second_timer_ovf_evt |=> timer_control_q[7])
        else $error("second overflow flag not set");
    ////////////////////////////////////////////////////////////////////////
    chk_read_latency: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata))
        else $error("read answer dropped before taken");
    chk_resp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("write answer dropped before taken");
endmodule

bind csfr_low_page csfr_low_page_props u_props (.*);

// ### testbench/csfr_low_page_tb_top.sv
`include "csfr_defines.vh"

module csfr_low_page_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] PC = `CSFR_IDX_POWER_CTRL;
    localparam logic [9:0] TC = `CSFR_IDX_TIMER_CTRL;
    localparam logic [9:0] SC = `CSFR_IDX_SERIAL_CTRL;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_arready, s_axi_rvalid, s_axi_rready, irq_q;
    logic [7:0]  low_port_in, low_port_out_q, low_port_oe_n_q, ext_rdata_q;
    logic [7:0]  ext_addr_low, ext_wdata, stack_top_q, timer_control_q, d;
    logic [15:0] data_pointer_q;
    logic        low_port_pullup_enable_q, ext_access, ext_addr_phase;
    logic        ext_write_phase, power_on_reset, wake_event, frame_err_event;
    logic        cpu_clk_stop_q, periph_clk_stop_q, baud_doubler_q;
    logic        serial_mode_hi_q, first_timer_ovf_evt, second_timer_ovf_evt;
    logic        first_timer_vector, second_timer_vector, first_timer_run_q;
    logic        second_timer_run_q, ext_irq0_pin, ext_irq1_pin;
    logic        ext_irq0_vector, ext_irq1_vector;
    logic [9:0]  i;
    logic [7:0]  mdl [int];
    int          miscompares, comparisons, cyc;

    csfr_low_page u_dut (.*);

    initial begin
        aclk = 0;
        forever #5 aclk = ~aclk;
    end

    // tests need about 400 cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares++;
            end_sim;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
            miscompares++;
        end
    endtask

    task automatic settle;
        repeat (3) @(posedge aclk);
    endtask

    // response ready held back a random 0..2 cycles to stall the slave
    task automatic wr(input logic [9:0] a, input logic [7:0] v,
                      input logic [1:0] er = `CSFR_RESP_OKAY);
        logic aw_p, w_p;
        @(posedge aclk);
        s_axi_awaddr <= {a, 2'b00};
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        // local flags: the valid signals only update after this step
        aw_p = 1;
        w_p = 1;
        while (aw_p || w_p) begin
            @(posedge aclk);
            if (aw_p && s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 0;
                aw_p = 0;
            end
            if (w_p && s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 0;
                w_p = 0;
            end
        end
        repeat ($urandom_range(2)) @(posedge aclk);
        s_axi_bready <= 1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 0;
        chk(s_axi_bresp, er);
    endtask

    task automatic rc(input logic [9:0] a, input logic [7:0] e,
                      input logic [1:0] er = `CSFR_RESP_OKAY);
        @(posedge aclk);
        s_axi_araddr <= {a, 2'b00};
        s_axi_arvalid <= 1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 0;
        repeat ($urandom_range(2)) @(posedge aclk);
        s_axi_rready <= 1;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 0;
        chk(s_axi_rresp, er);
        chk(s_axi_rdata, {24'h0, e});
    endtask

    // pin path has a sync chain and filter, so poll briefly
    task automatic waitf(input int b, input logic e);
        for (int k = 0; k < 20 && timer_control_q[b] !== e; k++)
            @(posedge aclk);
        chk(timer_control_q[b], e);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        d = $urandom(53);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, ext_access, ext_addr_phase, ext_write_phase} = '0;
        {power_on_reset, wake_event, frame_err_event} = '0;
        {first_timer_ovf_evt, second_timer_ovf_evt} = '0;
        {first_timer_vector, second_timer_vector} = '0;
        {ext_irq0_vector, ext_irq1_vector} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {ext_addr_low, ext_wdata} = '0;
        s_axi_wstrb = 4'h1;
        {ext_irq0_pin, ext_irq1_pin} = 2'b11;
        low_port_in = 8'hFF;
        aresetn = 0;
        mdl[10'h081] = 8'h07;
        mdl[10'h082] = 8'h00;
        mdl[10'h083] = 8'h00;
        repeat (10) @(posedge aclk);
        aresetn <= 1;
        rc(`CSFR_IDX_STACK_TOP, 8'h07);
        rc(`CSFR_IDX_PULLUP_SEL, 8'hFF);
        rc(PC, 8'h30);
        rc(TC, 8'h00);
        chk(low_port_pullup_enable_q, 1'b1);
        $display("test reset done");
        for (int k = 0; k < 9; k++) begin
            d = $urandom;
            i = 10'h081 + k % 3;
            wr(i, d);
            mdl[i] = d;
            rc(i, mdl[i]);
            chk(stack_top_q, mdl[10'h081]);
            chk(data_pointer_q, {mdl[10'h083], mdl[10'h082]});
        end
        s_axi_wstrb <= 4'h0;
        wr(`CSFR_IDX_STACK_TOP, ~mdl[10'h081]);
        s_axi_wstrb <= 4'h1;
        rc(`CSFR_IDX_STACK_TOP, mdl[10'h081]);
        rc(10'h084, `CSFR_UNIMPL_BYTE);
        rc(10'h200, 8'h00, `CSFR_RESP_SLVERR);
        wr(10'h200, 8'h00, `CSFR_RESP_SLVERR);
        $display("test storage done");
        d = $urandom;
        low_port_in <= d;
        repeat (8) @(posedge aclk);
        rc(`CSFR_IDX_LOW_PORT, d);
        chk(ext_rdata_q, d);
        wr(`CSFR_IDX_PULLUP_SEL, 8'h00);
        rc(`CSFR_IDX_PULLUP_SEL, 8'hFE);
        chk(low_port_pullup_enable_q, 1'b0);
        wr(`CSFR_IDX_LOW_PORT, 8'h5A);
        settle;
        chk({low_port_oe_n_q, low_port_out_q}, 16'h5A00);
        d = $urandom;
        ext_addr_low <= d;
        ext_wdata <= ~d;
        ext_access <= 1;
        ext_addr_phase <= 1;
        settle;
        chk({low_port_oe_n_q, low_port_out_q}, {8'h00, d});
        ext_addr_phase <= 0;
        ext_write_phase <= 1;
        settle;
        chk({low_port_oe_n_q, low_port_out_q}, {8'h00, ~d});
        ext_write_phase <= 0;
        settle;
        chk(low_port_oe_n_q, 8'hFF);
        ext_access <= 0;
        $display("test port done");
        wr(PC, 8'h00);
        rc(PC, 8'h20);
        power_on_reset <= 1;
        @(posedge aclk);
        power_on_reset <= 0;
        rc(PC, 8'h30);
        d = $urandom & 8'h8C;
        wr(PC, d);
        rc(PC, d | 8'h20);
        chk(baud_doubler_q, d[7]);
        for (int k = 1; k < 3; k++) begin
            wr(PC, k[7:0]);
            settle;
            chk({cpu_clk_stop_q, periph_clk_stop_q}, {1'b1, k == 2});
            wake_event <= 1;
            @(posedge aclk);
            wake_event <= 0;
            settle;
            chk({cpu_clk_stop_q, periph_clk_stop_q}, 2'b00);
        end
        $display("test power done");
        wr(PC, 8'h00);
        wr(SC, 8'h80);
        rc(SC, 8'hFF);
        wr(PC, 8'h40);
        rc(SC, 8'h7F);
        frame_err_event <= 1;
        @(posedge aclk);
        frame_err_event <= 0;
        rc(SC, 8'hFF);
        wr(SC, 8'h00);
        rc(SC, 8'h7F);
        chk(serial_mode_hi_q, 1'b1);
        $display("test serial done");
        wr(`CSFR_IDX_IRQ_STATUS, 8'hFF);
        wr(`CSFR_IDX_IRQ_MASK, 8'h01);
        wr(TC, 8'h50);
        settle;
        chk({first_timer_run_q, second_timer_run_q}, 2'b11);
        first_timer_ovf_evt <= 1;
        second_timer_ovf_evt <= 1;
        @(posedge aclk);
        first_timer_ovf_evt <= 0;
        second_timer_ovf_evt <= 0;
        rc(TC, 8'hF0);
        chk(irq_q, 1'b1);
        first_timer_vector <= 1;
        @(posedge aclk);
        first_timer_vector <= 0;
        rc(TC, 8'hD0);
        wr(`CSFR_IDX_IRQ_MASK, 8'h00);
        settle;
        chk(irq_q, 1'b0);
        wr(`CSFR_IDX_IRQ_MASK, 8'h01);
        wr(`CSFR_IDX_IRQ_STATUS, 8'h01);
        settle;
        chk(irq_q, 1'b0);
        wr(TC, 8'h20);
        rc(TC, 8'h20);
        chk({first_timer_run_q, second_timer_run_q}, 2'b00);
        $display("test timer done");
        for (int n = 0; n < 2; n++) begin
            for (int t = 0; t < 2; t++) begin
                wr(TC, 8'(t << (2 * n)));
                if (n == 1) ext_irq1_pin <= 0;
                else ext_irq0_pin <= 0;
                waitf(2 * n + 1, 1'b1);
                if (n == 1) ext_irq1_vector <= 1;
                else ext_irq0_vector <= 1;
                @(posedge aclk);
                {ext_irq0_vector, ext_irq1_vector} <= 2'b00;
                settle;
                chk(timer_control_q[2 * n + 1], t == 0);
                {ext_irq0_pin, ext_irq1_pin} <= 2'b11;
                waitf(2 * n + 1, 1'b0);
            end
        end
        $display("test external done");
        end_sim;
    end
endmodule
